// >>> logic/vicr_top.sv
// Purpose: register interface and core of the vectored interrupt controller
// Assumes: inputs synchronous to ref_clk_in; reads answered one cycle later
// Notes: priority stack of eight levels
`timescale 1ns/1ps
module vicr_top (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // register port
  input wire logic [31:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // interrupt sources
  input wire logic [31:0] source_in,
  // processor request lines
  output logic normal_request_line_n_out,
  output logic fast_request_line_n_out
);

  // ************************************
  // state
  // ************************************
  logic [6:0] source_mode_array [vicr_pkg::NSRC];
  logic [31:0] source_vector_array [vicr_pkg::NSRC];
  logic [31:0] pending_flags;
  logic [31:0] enabled_mask;
  logic [31:0] fast_force;
  logic [31:0] prev_level;
  logic [31:0] spurious_vector;
  logic [1:0] debug_control;
  logic write_guard_enable;
  logic guard_violation;
  logic [11:0] guard_source;
  logic [4:0] current_source_number;
  logic [4:0] recorded_id;
  logic recorded_ok;
  logic [2:0] prio_stack [vicr_pkg::STACK_DEPTH];
  logic [4:0] id_stack [vicr_pkg::STACK_DEPTH];
  logic [3:0] depth;

  // ************************************
  // address decode
  // ************************************
  wire logic in_window;
  wire logic [11:0] ofs;
  wire logic [4:0] idx;
  wire logic wr;
  wire logic rd;
  wire logic in_mode;
  wire logic in_vec;
  wire logic protect_mode_bit;

  // see R1
  assign in_window = reg_addr_in[31:vicr_pkg::WIN_BITS] == vicr_pkg::BASE_ADDR[31:vicr_pkg::WIN_BITS];
  assign ofs = reg_addr_in[11:0];
  assign idx = ofs[6:2];
  // see R22
  assign wr = reg_wr_in & in_window;
  assign rd = reg_rd_in & in_window;
  assign in_mode = ofs[11:7] == vicr_pkg::OFS_MODE[11:7];
  assign in_vec = ofs[11:7] == vicr_pkg::OFS_VEC[11:7];
  assign protect_mode_bit = debug_control[vicr_pkg::DBG_PROTECT_MODE_BIT_BIT];

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = a == o;
  endfunction : hit

  wire logic wr_guarded;
  wire logic wr_allowed;
  wire logic blocked;
  wire logic wr_en;
  wire logic wr_dis;
  wire logic wr_clr;
  wire logic wr_set;
  wire logic wr_eos;
  wire logic wr_ivr;
  wire logic wr_ffen;
  wire logic wr_ffdis;
  wire logic rd_ivr;
  wire logic rd_fvr;
  wire logic rd_wgs;

  assign wr_guarded = in_mode | in_vec | hit(ofs, vicr_pkg::OFS_SPU) | hit(ofs, vicr_pkg::OFS_DBG);
  // see R7
  assign blocked = wr & wr_guarded & write_guard_enable;
  assign wr_allowed = wr & ~write_guard_enable;
  // see R5
  assign wr_en = wr & hit(ofs, vicr_pkg::OFS_EN);
  assign wr_dis = wr & hit(ofs, vicr_pkg::OFS_DIS);
  assign wr_clr = wr & hit(ofs, vicr_pkg::OFS_CLR);
  assign wr_set = wr & hit(ofs, vicr_pkg::OFS_SET);
  // see R20
  assign wr_eos = wr & hit(ofs, vicr_pkg::OFS_EOS);
  assign wr_ivr = wr & hit(ofs, vicr_pkg::OFS_IVR);
  // see R6
  assign wr_ffen = wr & hit(ofs, vicr_pkg::OFS_FFEN);
  assign wr_ffdis = wr & hit(ofs, vicr_pkg::OFS_FFDIS);
  assign rd_ivr = rd & hit(ofs, vicr_pkg::OFS_IVR);
  assign rd_fvr = rd & hit(ofs, vicr_pkg::OFS_FVR);
  assign rd_wgs = rd & hit(ofs, vicr_pkg::OFS_WGM + 12'h004);

  // ************************************
  // priority selection
  // ************************************
  wire logic [95:0] prio_flat;
  wire logic [31:0] normal_req;
  wire logic [8:0] best;
  wire logic best_valid;
  wire logic [2:0] best_prio;
  wire logic [4:0] best_id;
  wire logic [2:0] cur_prio;
  wire logic irq_go;

  // see R8
  function automatic logic [8:0] find_best(input logic [31:0] req, input logic [95:0] pr);
    logic found;
    logic [2:0] bp;
    logic [4:0] bi;
    found = 1'b0;
    bp = 3'h0;
    bi = 5'h00;
    // see R9
    for (int i = vicr_pkg::NSRC - 1; i >= 1; i--) begin
      if (req[i] && (!found || pr[i*3 +: 3] >= bp)) begin
        found = 1'b1;
        bp = pr[i*3 +: 3];
        bi = 5'(i);
      end
    end
    find_best = {found, bp, bi};
  endfunction : find_best

  assign normal_req = pending_flags & enabled_mask & ~fast_force;
  assign best = find_best(normal_req, prio_flat);
  assign best_valid = best[8];
  assign best_prio = best[7:5];
  assign best_id = best[4:0];
  assign cur_prio = depth != 4'h0 ? prio_stack[3'(depth - 4'h1)] : 3'h0;
  assign irq_go = best_valid && (depth == 4'h0 || best_prio > cur_prio);

  // ************************************
  // acknowledge and stack control
  // ************************************
  wire logic push_now;
  wire logic [4:0] push_id;
  wire logic [2:0] push_prio;
  wire logic pop_now;
  wire logic [31:0] ack_vec;
  wire logic fiq_ack;

  // see R18, R19
  assign push_now = (rd_ivr & irq_go & ~protect_mode_bit)
    | (wr_ivr & protect_mode_bit & recorded_ok);
  assign push_id = protect_mode_bit ? recorded_id : best_id;
  assign push_prio = protect_mode_bit ? prio_flat[push_id*3 +: 3] : best_prio;
  assign pop_now = wr_eos & (depth != 4'h0);
  assign fiq_ack = rd_fvr & ~fast_force[0];
  assign ack_vec = ((push_now & depth != vicr_pkg::STACK_DEPTH) ? (32'h1 << push_id) : 32'h0)
    | {31'h0, fiq_ack};

  // ************************************
  // per-source detection
  // ************************************
  wire logic [31:0] level;
  wire logic [31:0] is_edge;
  wire logic [31:0] next_pending;

  for (genvar i = 0; i < vicr_pkg::NSRC; i++) begin : g_src
    assign prio_flat[i*3 +: 3] = source_mode_array[i][vicr_pkg::PRIO_LSB +: 3];
    // see R10, R11, R12
    assign level[i] = source_in[i]
      ^ (vicr_pkg::EXT_SRC_MASK[i] & ~source_mode_array[i][vicr_pkg::TYPE_LSB + 1]);
    assign is_edge[i] = source_mode_array[i][vicr_pkg::TYPE_LSB];
    // detected edge wins over a clear in the same cycle
    assign next_pending[i] = is_edge[i]
      ? ((level[i] & ~prev_level[i]) | (wr_set & reg_wdata_in[i])
         | (pending_flags[i] & ~(wr_clr & reg_wdata_in[i]) & ~ack_vec[i]))
      : (level[i] | (wr_set & reg_wdata_in[i]));
  end

  // ************************************
  // source registers
  // ************************************
  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < vicr_pkg::NSRC; i++) begin
      if (reset_in) begin
        // see R2
        source_mode_array[i] <= vicr_pkg::RESET_WORD[6:0];
        // see R3
        source_vector_array[i] <= vicr_pkg::RESET_WORD;
      end else if (wr_allowed && in_mode && idx == 5'(i)) begin
        source_mode_array[i] <= reg_wdata_in[6:0] & vicr_pkg::MODE_MASK;
      end else if (wr_allowed && in_vec && idx == 5'(i)) begin
        source_vector_array[i] <= reg_wdata_in;
      end
    end
  end

  // ************************************
  // pending, mask, fast force
  // ************************************
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      // see R4
      pending_flags <= vicr_pkg::EXT_SRC_MASK & ~source_in;
      prev_level <= vicr_pkg::RESET_WORD;
      enabled_mask <= vicr_pkg::RESET_WORD;
      fast_force <= vicr_pkg::RESET_WORD;
    end else begin
      pending_flags <= next_pending;
      prev_level <= level;
      if (wr_en) begin
        enabled_mask <= enabled_mask | reg_wdata_in;
      end else if (wr_dis) begin
        enabled_mask <= enabled_mask & ~reg_wdata_in;
      end
      if (wr_ffen) begin
        fast_force <= fast_force | reg_wdata_in;
      end else if (wr_ffdis) begin
        fast_force <= fast_force & ~reg_wdata_in;
      end
    end
  end

  // ************************************
  // control and guard registers
  // ************************************
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      spurious_vector <= vicr_pkg::RESET_WORD;
      debug_control <= 2'h0;
      write_guard_enable <= 1'b0;
      guard_violation <= 1'b0;
      guard_source <= 12'h000;
    end else begin
      if (wr_allowed && hit(ofs, vicr_pkg::OFS_SPU)) begin
        spurious_vector <= reg_wdata_in;
      end
      if (wr_allowed && hit(ofs, vicr_pkg::OFS_DBG)) begin
        debug_control <= reg_wdata_in[1:0];
      end
      if (wr && hit(ofs, vicr_pkg::OFS_WGM)) begin
        write_guard_enable <= reg_wdata_in[vicr_pkg::WG_EN_BIT];
      end
      // violation wins over the read that clears it
      if (blocked) begin
        guard_violation <= 1'b1;
        guard_source <= ofs;
      end else if (rd_wgs) begin
        guard_violation <= 1'b0;
      end
    end
  end

  // ************************************
  // current interrupt and stack
  // ************************************
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      current_source_number <= 5'h00;
      recorded_id <= 5'h00;
      recorded_ok <= 1'b0;
      depth <= 4'h0;
      for (int i = 0; i < vicr_pkg::STACK_DEPTH; i++) begin
        prio_stack[i] <= 3'h0;
        id_stack[i] <= 5'h00;
      end
    end else begin
      // see R18, R19
      if (rd_ivr) begin
        recorded_id <= best_id;
        recorded_ok <= irq_go;
      end
      if (push_now && depth != vicr_pkg::STACK_DEPTH) begin
        prio_stack[3'(depth)] <= push_prio;
        id_stack[3'(depth)] <= push_id;
        depth <= depth + 4'h1;
        // see R21
        current_source_number <= push_id;
      end else if (pop_now) begin
        depth <= depth - 4'h1;
        if (depth > 4'h1) begin
          current_source_number <= id_stack[3'(depth - 4'h2)];
        end
      end
    end
  end

  // ************************************
  // read data
  // ************************************
  logic [31:0] next_rdata;
  wire logic fiq_go;

  assign fiq_go = |(pending_flags & enabled_mask & (fast_force | 32'h1));

  always_comb begin
    next_rdata = 32'h0;
    if (in_mode) begin
      next_rdata = {25'h0, source_mode_array[idx]};
    end else if (in_vec) begin
      next_rdata = source_vector_array[idx];
    end else begin
      case (ofs)
        // see R14, R15
        vicr_pkg::OFS_IVR: next_rdata = irq_go ? source_vector_array[best_id] : spurious_vector;
        // see R16, R17
        vicr_pkg::OFS_FVR: next_rdata = fiq_go ? source_vector_array[0] : spurious_vector;
        vicr_pkg::OFS_ISR: next_rdata = {27'h0, current_source_number};
        vicr_pkg::OFS_PEND: next_rdata = pending_flags;
        vicr_pkg::OFS_MASK: next_rdata = enabled_mask;
        vicr_pkg::OFS_CORE: next_rdata = {30'h0, ~normal_request_line_n_out, ~fast_request_line_n_out};
        vicr_pkg::OFS_SPU: next_rdata = spurious_vector;
        vicr_pkg::OFS_DBG: next_rdata = {30'h0, debug_control};
        vicr_pkg::OFS_FFST: next_rdata = fast_force;
        vicr_pkg::OFS_WGM: next_rdata = {31'h0, write_guard_enable};
        vicr_pkg::OFS_WGS: next_rdata = {8'h0, 4'h0, guard_source, 7'h0, guard_violation};
        // see R22
        default: next_rdata = 32'h0;
      endcase
    end
  end

  // ************************************
  // outputs
  // ************************************
  wire logic gmsk;

  assign gmsk = debug_control[vicr_pkg::DBG_GMSK_BIT];

  // see R23
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= 32'h0;
      normal_request_line_n_out <= 1'b1;
      fast_request_line_n_out <= 1'b1;
    end else begin
      reg_rdata_out <= rd ? next_rdata : 32'h0;
      normal_request_line_n_out <= ~(irq_go & ~gmsk);
      fast_request_line_n_out <= ~(fiq_go & ~gmsk);
    end
  end

endmodule : vicr_top

// >>> logic/vicr_pkg.sv
// Purpose: constants of the vectored interrupt controller registers
// Assumes: 32 sources, source 0 is the fast source and the only external input
// Notes: offsets are byte offsets inside the 4-Kbyte window
//
// Operation
// R1: decode one 4-Kbyte register window based at 0xffff_f000
// R2: 32 read-write source mode registers at 0x00..0x7c, reset zero
// R3: 32 read-write source handler-address registers at 0x80..0xfc, reset zero
// R4: pending bit of external input reflects its level at reset; others clear
// R5: enable, disable, clear, set commands write-only at 0x120..0x12c, bit per source
// R6: fast-force enable/disable at 0x140/0x144, status read-only at 0x148
// R7: writes to mode, vector, spurious registers ignored while write guard set
// R8: 3-bit source priority per mode register, 0 lowest, 7 highest
// R9: priority field of source 0 is disregarded
// R10: internal types 0,2 high level; 1,3 rising edge; polarity fixed
// R11: external type 0 low level, type 1 falling edge
// R12: external type 2 high level, type 3 rising edge
// R13: software loads each vector with the full handler address
// R14: normal vector read returns vector selected by current interrupt number
// R15: normal vector read with no current interrupt returns spurious vector
// R16: fast vector read returns source 0 vector whatever caused it
// R17: fast vector read with no fast interrupt returns spurious vector
// R18: normal mode read selects, returns, records, pushes priority, acknowledges
// R19: protect mode read only selects, returns, records; write does push and ack
// R20: any write to end-of-service register ends handling; data ignored
// R21: status register returns number of source being serviced
// R22: reserved offsets read zero and ignore writes
// R23: single-cycle accesses; read side effects in the capture cycle
package vicr_pkg;
  localparam logic [31:0] BASE_ADDR = 32'hffff_f000;
  localparam int WIN_BITS = 12;
  localparam logic [11:0] OFS_MODE = 12'h000;
  localparam logic [11:0] OFS_VEC = 12'h080;
  localparam logic [11:0] OFS_IVR = 12'h100;
  localparam logic [11:0] OFS_FVR = 12'h104;
  localparam logic [11:0] OFS_ISR = 12'h108;
  localparam logic [11:0] OFS_PEND = 12'h10c;
  localparam logic [11:0] OFS_MASK = 12'h110;
  localparam logic [11:0] OFS_CORE = 12'h114;
  localparam logic [11:0] OFS_EN = 12'h120;
  localparam logic [11:0] OFS_DIS = 12'h124;
  localparam logic [11:0] OFS_CLR = 12'h128;
  localparam logic [11:0] OFS_SET = 12'h12c;
  localparam logic [11:0] OFS_EOS = 12'h130;
  localparam logic [11:0] OFS_SPU = 12'h134;
  localparam logic [11:0] OFS_DBG = 12'h138;
  localparam logic [11:0] OFS_FFEN = 12'h140;
  localparam logic [11:0] OFS_FFDIS = 12'h144;
  localparam logic [11:0] OFS_FFST = 12'h148;
  localparam logic [11:0] OFS_WGM = 12'h1e4;
  localparam logic [11:0] OFS_WGS = 12'h1e8;
  localparam int NSRC = 32;
  localparam int PRIO_LSB = 0;
  localparam int TYPE_LSB = 5;
  localparam logic [6:0] MODE_MASK = 7'h67;
  localparam logic [31:0] EXT_SRC_MASK = 32'h0000_0001;
  localparam int DBG_PROTECT_MODE_BIT_BIT = 0;
  localparam int DBG_GMSK_BIT = 1;
  localparam int WG_EN_BIT = 0;
  localparam int WGS_VIOL_BIT = 0;
  localparam int WGS_SRC_LSB = 8;
  localparam int STACK_DEPTH = 8;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage : vicr_pkg

// >>> verif/vicr_properties.sv
// Purpose: port assertions of the interrupt controller registers
// Assumes: one clock, synchronous active high reset
// Notes: shadows follow guarded writes to spurious and vector 1
`timescale 1ns/1ps
module vicr_properties (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // register port
  input wire logic [31:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // sources and lines
  input wire logic [31:0] source_in,
  input wire logic normal_request_line_n_out,
  input wire logic fast_request_line_n_out
);
  // ****************
  // shadows and checks
  // ****************
  wire logic in_win = reg_addr_in[31:12] == vicr_pkg::BASE_ADDR[31:12];
  wire logic [11:0] ofs = reg_addr_in[11:0];
  wire logic rd_win = reg_rd_in && in_win;
  logic guard;
  logic [31:0] spu_sh;
  logic [31:0] vec1_sh;
  wire logic wr_ok = reg_wr_in && in_win && !guard;
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      guard <= 1'b0;
      spu_sh <= 32'h0;
      vec1_sh <= 32'h0;
    end else begin
      if (reg_wr_in && in_win && ofs == vicr_pkg::OFS_WGM) guard <= reg_wdata_in[vicr_pkg::WG_EN_BIT];
      if (wr_ok && ofs == vicr_pkg::OFS_SPU) spu_sh <= reg_wdata_in;
      if (wr_ok && ofs == 12'h084) vec1_sh <= reg_wdata_in;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  a_idle_rdata: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside answer cycle");
  a_out_window: assert property (reg_rd_in && !in_win |=> reg_rdata_out == 32'h0)
    else $error("read outside window answered");
  a_reserved_zero: assert property (rd_win && (ofs == 12'h118 || ofs == 12'h13c || ofs == 12'h1ec) |=>
    reg_rdata_out == 32'h0) else $error("reserved offset not zero");
  a_cmd_zero: assert property (rd_win && ofs >= vicr_pkg::OFS_EN && ofs <= vicr_pkg::OFS_SET |=>
    reg_rdata_out == 32'h0) else $error("command register readable");
  a_mode_fields: assert property (rd_win && ofs < vicr_pkg::OFS_VEC |=>
    (reg_rdata_out & 32'hffff_ff98) == 32'h0) else $error("mode register extra bits");
  a_spu_guard: assert property (rd_win && ofs == vicr_pkg::OFS_SPU |=> reg_rdata_out == $past(spu_sh))
    else $error("spurious vector wrong");
  a_vec_hold: assert property (rd_win && ofs == 12'h084 |=> reg_rdata_out == $past(vec1_sh))
    else $error("vector register wrong");
  a_reset_quiet: assert property (disable iff (1'b0) reset_in |=> reg_rdata_out == 32'h0 &&
    normal_request_line_n_out && fast_request_line_n_out) else $error("outputs not quiet in reset");
endmodule : vicr_properties
bind vicr_top vicr_properties vicr_properties_inst (.ref_clk_in, .reset_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .source_in, .normal_request_line_n_out, .fast_request_line_n_out);

// >>> verif/vicr_source_model.sv
// Purpose: model of the peripheral and external interrupt sources
// Assumes: levels requested by the bench
// Notes: slow mode adds one stage of lag
`timescale 1ns/1ps
module vicr_source_model (
  // clock
  input wire logic ref_clk_in,
  // bench requests
  input wire logic [31:0] level_in,
  input wire logic slow_in,
  // sources to the controller
  output logic [31:0] source_out
);
  // ****************
  // source lag
  // ****************
  logic [31:0] stage;
  always_ff @(posedge ref_clk_in) begin
    stage <= level_in;
    source_out <= slow_in ? stage : level_in;
  end
endmodule : vicr_source_model

// >>> verif/tb.sv
// Purpose: self-checking bench of the interrupt controller registers
// Assumes: offsets relative to the window base
// Notes: table rows first, then hand-written cases
`timescale 1ns/1ps
module tb;
  // ****************
  // signals and tasks
  // ****************
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] v;} vicr_row_type;
  logic ref_clk_in;
  logic reset_in;
  logic [31:0] reg_addr_in;
  logic [31:0] reg_wdata_in;
  logic reg_wr_in;
  logic reg_rd_in;
  logic [31:0] reg_rdata_out;
  logic [31:0] source_in;
  logic normal_request_line_n_out;
  logic fast_request_line_n_out;
  logic [31:0] level;
  logic slow;
  int n_errors = 0;
  int cmp_count = 0;
  vicr_row_type rows [21] = '{'{1'b0, 12'h000, 32'h0}, '{1'b0, 12'h0fc, 32'h0}, '{1'b0, 12'h10c, 32'h1},
    '{1'b0, 12'h108, 32'h0}, '{1'b0, 12'h110, 32'h0}, '{1'b0, 12'h114, 32'h0}, '{1'b0, 12'h148, 32'h0},
    '{1'b0, 12'h134, 32'h0}, '{1'b0, 12'h1e4, 32'h0}, '{1'b0, 12'h1e8, 32'h0}, '{1'b0, 12'h120, 32'h0},
    '{1'b1, 12'h014, 32'hffff_ffff}, '{1'b0, 12'h014, 32'h67}, '{1'b1, 12'h084, 32'h1234_5678},
    '{1'b0, 12'h084, 32'h1234_5678}, '{1'b1, 12'h134, 32'h5a5a_0000}, '{1'b0, 12'h134, 32'h5a5a_0000},
    '{1'b1, 12'h118, 32'hffff_ffff}, '{1'b0, 12'h118, 32'h0}, '{1'b1, 12'h13c, 32'hffff_ffff},
    '{1'b0, 12'h13c, 32'h0}};
  vicr_source_model vicr_source_model_inst (.ref_clk_in, .level_in(level), .slow_in(slow), .source_out(source_in));
  vicr_top vicr_top_inst (.ref_clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .source_in, .normal_request_line_n_out, .fast_request_line_n_out);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
      n_errors++;
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= vicr_pkg::BASE_ADDR + a;
    reg_wdata_in <= v;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= vicr_pkg::BASE_ADDR + a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out & m, e);
  endtask : rdc
  task automatic lchk(input logic [1:0] e);
    repeat (4) @(posedge ref_clk_in);
    #1;
    chk({30'h0, normal_request_line_n_out, fast_request_line_n_out}, {30'h0, e});
  endtask : lchk
  task automatic wait_low(input logic f);
    int i;
    i = 0;
    while ((f ? fast_request_line_n_out : normal_request_line_n_out) !== 1'b0 && i < 40) begin
      @(posedge ref_clk_in);
      i++;
    end
    #1;
    chk({31'h0, f ? fast_request_line_n_out : normal_request_line_n_out}, 32'h0);
  endtask : wait_low
  task automatic complete_run();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_errors++;
    complete_run();
  end
  initial begin
    reset_in = 1'b1;
    reg_addr_in = 32'h0;
    reg_wdata_in = 32'h0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    level = 32'h0;
    slow = 1'b0;
    repeat (5) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr({20'h0, rows[i].a}, rows[i].v);
      else rdc({20'h0, rows[i].a}, rows[i].v);
    end
    // trigger types on external source 0 and internal source 2
    for (int s = 0; s < 3; s += 2) begin
      for (int t = 0; t < 4; t++) begin
        logic act;
        act = (s == 0) ? t[1] : 1'b1;
        slow <= t[1];
        wr(32'(s * 4), 32'(t << 5));
        @(posedge ref_clk_in) level[s] <= !act;
        repeat (4) @(posedge ref_clk_in);
        wr(12'h128, 32'h1 << s);
        rdc(12'h10c, 32'h0, 32'h1 << s);
        @(posedge ref_clk_in) level[s] <= act;
        repeat (3) @(posedge ref_clk_in);
        rdc(12'h10c, 32'h1 << s, 32'h1 << s);
        @(posedge ref_clk_in) level[s] <= !act;
        repeat (3) @(posedge ref_clk_in);
        rdc(12'h10c, 32'(t % 2) << s, 32'h1 << s);
        wr(12'h128, 32'h1 << s);
      end
    end
    // normal interrupt, acknowledge, end of service, spurious
    wr(12'h004, 32'h63);
    wr(12'h120, 32'h2);
    @(posedge ref_clk_in) level[1] <= 1'b1;
    wait_low(1'b0);
    rdc(12'h100, 32'h1234_5678);
    rdc(12'h108, 32'h1);
    lchk(2'b11);
    wr(12'h130, 32'h0);
    rdc(12'h100, 32'h5a5a_0000);
    // protect mode
    wr(12'h138, 32'h1);
    @(posedge ref_clk_in) level[1] <= 1'b0;
    @(posedge ref_clk_in) level[1] <= 1'b1;
    wait_low(1'b0);
    rdc(12'h100, 32'h1234_5678);
    lchk(2'b01);
    wr(12'h100, 32'h0);
    lchk(2'b11);
    wr(12'h130, 32'hffff_ffff);
    wr(12'h138, 32'h0);
    // fast forcing and fast source
    wr(12'h140, 32'h8);
    rdc(12'h148, 32'h8);
    wr(12'h080, 32'h0f00_0000);
    wr(12'h120, 32'h9);
    @(posedge ref_clk_in) level[3] <= 1'b1;
    wait_low(1'b1);
    rdc(12'h104, 32'h0f00_0000);
    @(posedge ref_clk_in) level[3] <= 1'b0;
    wr(12'h144, 32'h8);
    rdc(12'h148, 32'h0);
    wr(12'h000, 32'h47);
    @(posedge ref_clk_in) level[0] <= 1'b1;
    wait_low(1'b1);
    lchk(2'b10);
    rdc(12'h104, 32'h0f00_0000);
    @(posedge ref_clk_in) level[0] <= 1'b0;
    lchk(2'b11);
    rdc(12'h104, 32'h5a5a_0000);
    // write guard
    wr(12'h1e4, 32'h1);
    wr(12'h134, 32'h0bad_0000);
    wr(12'h004, 32'h0);
    rdc(12'h134, 32'h5a5a_0000);
    rdc(12'h004, 32'h63);
    rdc(12'h1e8, 32'h401);
    wr(12'h1e4, 32'h0);
    // outside the window
    wr(32'h0000_1134, 32'hffff_ffff);
    rdc(32'h0000_1134, 32'h0);
    rdc(12'h134, 32'h5a5a_0000);
    // reset with external input high
    @(posedge ref_clk_in) level[0] <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    reset_in <= 1'b1;
    repeat (5) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    rdc(12'h10c, 32'h0, 32'h1);
    rdc(12'h014, 32'h0);
    complete_run();
  end
endmodule : tb
